// ### inc/ialc_consts.svh
// Purpose: Offsets, field positions, reset values and codes for the
//          internal arbiter slice and register lock control bank.
// Assumes: 8-bit configuration index, byte-wide registers.
// Notes:   Included by the package and by the design.
//
// Summary of operation
// - Write-bus slice of 33 MHz PCI writes equals clock-control bits 7-5, 0-7 clocks.
// - Miss-read bit 4 clear: no PCI read retry until read issued to memory.
// - Clock-control bit 3 set turns on write-bus pipelining; reset leaves it off.
// - Ratio field decode: 110 is 2x, 101 is 2.5x, 011 is 3x, others reserved.
// - Graphics-port write slice comes from write-arbiter bits 7-4, 0-15 clocks.
// - 66 MHz PCI write slice comes from write-arbiter bits 3-0, 0-15 clocks.
// - 66 MHz PCI read slice comes from read-arbiter bits 7-4, 0-15 clocks.
// - 33 MHz PCI read slice comes from read-arbiter bits 3-0, 0-15 clocks.
// - Lock bit 7 set makes interrupt line register at 3Ch writable.
// - Lock bit 6 set makes graphics-port registers b0h-b7h writable.
// - Lock bit 5 set makes power management registers e0h-e7h writable.
// - Lock bit 4 set makes PLL control register at edh writable.
// - Lock bit 3 set makes companion bridge device id at 02h-03h writable.
// - A further lock bit makes the PM2 control base at e8h-e9h writable.
// - A further lock bit makes the capabilities pointer at 34h writable.
// - A further lock bit makes subsystem vendor id at 2ch-2dh writable.
// - Broadcast bit 0, reset 1, sends interrupt-ack and special cycles to both buses.
// - Slice is guaranteed minimum ownership, counted from grant with idle bus.
`ifndef IALC_CONSTS_SVH
`define IALC_CONSTS_SVH

`define IALC_OFS_CLKCTL   8'h8d
`define IALC_OFS_WRSLICE  8'h8e
`define IALC_OFS_RDSLICE  8'h8f
`define IALC_OFS_LOCK     8'h90
`define IALC_OFS_BCAST    8'h91
`define IALC_OFS_RSVD_LO  8'h92
`define IALC_OFS_RSVD_HI  8'haf

`define IALC_RST_CLKCTL   8'h00
`define IALC_RST_WRSLICE  8'h00
`define IALC_RST_RDSLICE  8'h00
`define IALC_RST_LOCK     8'h00
`define IALC_RST_BCAST    8'h13
`define IALC_MASK_BCAST   8'h13

`define IALC_CLK_PCI33_TO_MEMORY_WRITE_HI  7
`define IALC_CLK_PCI33_TO_MEMORY_WRITE_LO  5
`define IALC_CLK_MISSRD   4
`define IALC_CLK_PIPE     3
`define IALC_CLK_RATIO_HI 2
`define IALC_BCAST_BIT    0

`define IALC_RATIO_2X     3'h6
`define IALC_RATIO_2P5X   3'h5
`define IALC_RATIO_3X     3'h3

`define IALC_LK_INTLINE   7
`define IALC_LK_GPORT     6
`define IALC_LK_PM        5
`define IALC_LK_PLL       4
`define IALC_LK_DID       3
`define IALC_LK_PM2       2
`define IALC_LK_CAPPTR    1
`define IALC_LK_SSVID     0

`define IALC_T_INTLINE    8'h3c
`define IALC_T_GPORT_LO   8'hb0
`define IALC_T_GPORT_HI   8'hb7
`define IALC_T_PM_LO      8'he0
`define IALC_T_PM_HI      8'he7
`define IALC_T_PLL        8'hed
`define IALC_T_DID_LO     8'h02
`define IALC_T_DID_HI     8'h03
`define IALC_T_PM2_LO     8'he8
`define IALC_T_PM2_HI     8'he9
`define IALC_T_CAPPTR     8'h34
`define IALC_T_SSVID_LO   8'h2c
`define IALC_T_SSVID_HI   8'h2d

`define IALC_NUM_REQ      5
`define IALC_SLICE_W      4

`endif

// ### inc/ialc_pkg.sv
// Purpose: Types for the internal arbiter slice and lock control bank.
// Assumes: Constants come from ialc_consts.svh.
// Notes:   Requester order: 33 MHz write, graphics write, 66 MHz write,
//          66 MHz read, 33 MHz read.
`include "ialc_consts.svh"
package ialc_pkg;

   typedef enum logic [1:0] {SL_IDLE, SL_RUN, SL_DONE} ialc_slice_t;

   typedef struct packed {
      logic [7:0]                                 clkctl;
      logic [7:0]                                 wrslice;
      logic [7:0]                                 rdslice;
      logic [7:0]                                 lock;
      logic [7:0]                                 bcast;
      logic [7:0]                                 rdata;
      ialc_slice_t [`IALC_NUM_REQ-1:0]            st;
      logic [`IALC_NUM_REQ-1:0][`IALC_SLICE_W-1:0] cnt;
   } ialc_state_t;

endpackage

// ### logic/ialc_bank.sv
// Purpose: Slice, pipeline, clock ratio, broadcast and register lock
//          control for the internal bus arbiter, with slice timers.
// Assumes: Requests and grants come from logic on mclk.
// Notes:   Lock targets live elsewhere; this bank only qualifies
//          their writes through cfg_target_wr_ok.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "ialc_consts.svh"
module ialc_bank
   import ialc_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic                     mclk,             // 100 MHz clock
   input  wire logic                     rst_n,            // Sync reset, low
   input  wire logic [ADDR_W-1:0]        addr,             // Config index
   input  wire logic [7:0]               wdata,            // Write data
   input  wire logic                     wr,               // Write strobe
   input  wire logic                     rd,               // Read strobe
   output logic      [7:0]               rdata,            // Read data, next cycle
   input  wire logic [`IALC_NUM_REQ-1:0] grant,            // Per-requester grant
   input  wire logic                     wbus_idle,        // Write bus idle
   input  wire logic                     rbus_idle,        // Read bus idle
   input  wire logic                     mem_read_issued,  // 33 MHz read sent on
   output logic      [`IALC_NUM_REQ-1:0] slice_hold,       // Ownership guaranteed
   output logic      [`IALC_NUM_REQ-1:0] slice_expired,    // Slice used up
   output logic                          pci33_retry_ok,   // Read may be retried
   output logic                          wbus_pipe_en,     // Write bus pipelining
   output logic                          ratio_2x,         // Host/PCI 2x
   output logic                          ratio_2p5x,       // Host/PCI 2.5x
   output logic                          ratio_3x,         // Host/PCI 3x
   output logic                          ratio_reserved,   // Reserved ratio code
   output logic                          bcast_en,         // Broadcast ack/special
   output logic      [7:0]               unlock,           // Lock register bits
   output logic                          cfg_target_wr_ok  // Target write permitted
);

   // Decode needs a full byte of index; refuse narrower buses at elaboration
   if (ADDR_W < 8)
   begin : g_bad_addr_w
      $error("ialc_bank: ADDR_W must be at least 8");
   end

   ialc_state_t s_reg;
   ialc_state_t s_next;

   logic [7:0]                         idx;
   logic                               hit_any;
   logic                               hit_ok;
   logic [`IALC_NUM_REQ-1:0][`IALC_SLICE_W-1:0] slice_val;
   logic [`IALC_NUM_REQ-1:0]           bus_idle;

   // Only the low byte decodes; upper address bits are ignored
   assign idx = addr[7:0];

   always_comb
   begin
      slice_val[0] = {1'b0, s_reg.clkctl[`IALC_CLK_PCI33_TO_MEMORY_WRITE_HI:`IALC_CLK_PCI33_TO_MEMORY_WRITE_LO]};
      slice_val[1] = s_reg.wrslice[7:4];
      slice_val[2] = s_reg.wrslice[3:0];
      slice_val[3] = s_reg.rdslice[7:4];
      slice_val[4] = s_reg.rdslice[3:0];
      bus_idle     = {rbus_idle, rbus_idle, wbus_idle, wbus_idle, wbus_idle};
   end

   // Lock target decode; the lock value is the registered one, so a
   // lock write only affects accesses after it
   always_comb
   begin
      hit_any = 1'b1;
      hit_ok  = 1'b0;
      if (idx == `IALC_T_INTLINE)
         hit_ok = s_reg.lock[`IALC_LK_INTLINE];
      else if (idx >= `IALC_T_GPORT_LO && idx <= `IALC_T_GPORT_HI)
         hit_ok = s_reg.lock[`IALC_LK_GPORT];
      else if (idx >= `IALC_T_PM_LO && idx <= `IALC_T_PM_HI)
         hit_ok = s_reg.lock[`IALC_LK_PM];
      else if (idx == `IALC_T_PLL)
         hit_ok = s_reg.lock[`IALC_LK_PLL];
      else if (idx >= `IALC_T_DID_LO && idx <= `IALC_T_DID_HI)
         hit_ok = s_reg.lock[`IALC_LK_DID];
      else if (idx >= `IALC_T_PM2_LO && idx <= `IALC_T_PM2_HI)
         hit_ok = s_reg.lock[`IALC_LK_PM2];
      else if (idx == `IALC_T_CAPPTR)
         hit_ok = s_reg.lock[`IALC_LK_CAPPTR];
      else if (idx >= `IALC_T_SSVID_LO && idx <= `IALC_T_SSVID_HI)
         hit_ok = s_reg.lock[`IALC_LK_SSVID];
      else
         hit_any = 1'b0;
   end

   always_comb
   begin
      s_next = s_reg;

      if (wr)
      begin
         unique case (idx)
            `IALC_OFS_CLKCTL:  s_next.clkctl  = wdata;
            `IALC_OFS_WRSLICE: s_next.wrslice = wdata;
            `IALC_OFS_RDSLICE: s_next.rdslice = wdata;
            `IALC_OFS_LOCK:    s_next.lock    = wdata;
            // Only documented/default-set bits are stored
            `IALC_OFS_BCAST:   s_next.bcast   = wdata & `IALC_MASK_BCAST;
            default:           s_next.rdata   = s_reg.rdata;
         endcase
      end

      if (rd)
      begin
         unique case (idx)
            `IALC_OFS_CLKCTL:  s_next.rdata = s_reg.clkctl;
            `IALC_OFS_WRSLICE: s_next.rdata = s_reg.wrslice;
            `IALC_OFS_RDSLICE: s_next.rdata = s_reg.rdslice;
            `IALC_OFS_LOCK:    s_next.rdata = s_reg.lock;
            `IALC_OFS_BCAST:   s_next.rdata = s_reg.bcast;
            default:           s_next.rdata = 8'h00;
         endcase
      end
      else
         s_next.rdata = 8'h00;

      // Slice timers; slice 0 gives no guaranteed ownership
      for (int i = 0; i < `IALC_NUM_REQ; i++)
      begin
         unique case (s_reg.st[i])
            SL_IDLE:
            begin
               if (grant[i] && bus_idle[i])
               begin
                  s_next.cnt[i] = slice_val[i];
                  s_next.st[i]  = (slice_val[i] == '0) ? SL_DONE : SL_RUN;
               end
            end
            SL_RUN:
            begin
               if (!grant[i])
                  s_next.st[i] = SL_IDLE;
               else if (s_reg.cnt[i] <= `IALC_SLICE_W'(1))
               begin
                  s_next.cnt[i] = '0;
                  s_next.st[i]  = SL_DONE;
               end
               else
                  s_next.cnt[i] = s_reg.cnt[i] - `IALC_SLICE_W'(1);
            end
            SL_DONE:
            begin
               if (!grant[i])
                  s_next.st[i] = SL_IDLE;
            end
            default:
               s_next.st[i] = SL_IDLE;
         endcase
      end

      if (!rst_n)
      begin
         s_next.clkctl  = `IALC_RST_CLKCTL;
         s_next.wrslice = `IALC_RST_WRSLICE;
         s_next.rdslice = `IALC_RST_RDSLICE;
         s_next.lock    = `IALC_RST_LOCK;
         s_next.bcast   = `IALC_RST_BCAST;
         s_next.rdata   = 8'h00;
         for (int i = 0; i < `IALC_NUM_REQ; i++)
         begin
            s_next.st[i]  = SL_IDLE;
            s_next.cnt[i] = '0;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      s_reg <= s_next;
   end

   always_comb
   begin
      rdata = s_reg.rdata;
      for (int i = 0; i < `IALC_NUM_REQ; i++)
      begin
         slice_hold[i]    = (s_reg.st[i] == SL_RUN);
         slice_expired[i] = (s_reg.st[i] == SL_DONE);
      end
      // Bit low keeps the read pending until memory has it
      pci33_retry_ok = (s_reg.st[4] == SL_DONE) &&
                       (s_reg.clkctl[`IALC_CLK_MISSRD] || mem_read_issued);
      wbus_pipe_en   = s_reg.clkctl[`IALC_CLK_PIPE];
      ratio_2x       = (s_reg.clkctl[`IALC_CLK_RATIO_HI:0] == `IALC_RATIO_2X);
      ratio_2p5x     = (s_reg.clkctl[`IALC_CLK_RATIO_HI:0] == `IALC_RATIO_2P5X);
      ratio_3x       = (s_reg.clkctl[`IALC_CLK_RATIO_HI:0] == `IALC_RATIO_3X);
      ratio_reserved = !(ratio_2x || ratio_2p5x || ratio_3x);
      bcast_en       = s_reg.bcast[`IALC_BCAST_BIT];
      unlock         = s_reg.lock;
      // Locked targets ignore the write and keep their value
      cfg_target_wr_ok = wr && hit_any && hit_ok;
   end

endmodule

// ### tb/ialc_bank_sva.sv
// Purpose: Port checks for the arbiter slice and lock bank.
// Assumes: One clock domain, sync active-low reset.
// Notes:   Bound to every bank instance at the foot.
`timescale 1ns/1ps
module ialc_bank_sva
   import ialc_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic              mclk,             // Clock
   input wire logic              rst_n,            // Reset
   input wire logic [ADDR_W-1:0] addr,             // Index
   input wire logic [7:0]        wdata,            // Data
   input wire logic              wr,               // Write
   input wire logic              rd,               // Read
   input wire logic [7:0]        rdata,            // Answer
   input wire logic [4:0]        grant,            // Grants
   input wire logic              wbus_idle,        // Idle
   input wire logic [4:0]        slice_hold,       // Hold
   input wire logic [4:0]        slice_expired,    // Expired
   input wire logic              wbus_pipe_en,     // Pipe
   input wire logic              ratio_2x,         // 2x
   input wire logic              ratio_2p5x,       // 2.5x
   input wire logic              ratio_3x,         // 3x
   input wire logic              ratio_reserved,   // Reserved
   input wire logic              bcast_en,         // Broadcast
   input wire logic [7:0]        unlock,           // Locks
   input wire logic              cfg_target_wr_ok  // Gate
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside answer");
   AST_LOCK_WR: assert property (wr && addr == 8'h90 |=> unlock == $past(wdata))
      else $error("lock write not applied");
   AST_LOCK_RD: assert property (rd && addr == 8'h90 |=> rdata == unlock)
      else $error("lock readback wrong");
   AST_GATE_INT: assert property (wr && addr == 8'h3c |-> cfg_target_wr_ok == unlock[7])
      else $error("interrupt line gate wrong");
   AST_GATE_PLL: assert property (wr && addr == 8'hed |-> cfg_target_wr_ok == unlock[4])
      else $error("pll gate wrong");
   AST_GATE_WR: assert property (!wr |-> !cfg_target_wr_ok)
      else $error("gate open without write");
   AST_PIPE: assert property (wr && addr == 8'h8d |=> wbus_pipe_en == $past(wdata[3]))
      else $error("pipeline enable wrong");
   AST_RATIO: assert property (wr && addr == 8'h8d && wdata[2:0] == 3'h5 |=>
      ratio_2p5x && !ratio_2x && !ratio_3x)
      else $error("ratio 2.5x decode wrong");
   AST_RATIO_HOT: assert property ($onehot({ratio_2x, ratio_2p5x, ratio_3x, ratio_reserved}))
      else $error("ratio outputs not one-hot");
   AST_BCAST: assert property (wr && addr == 8'h91 |=> bcast_en == $past(wdata[0]))
      else $error("broadcast enable wrong");
   AST_SL_START: assert property ($rose(slice_hold[1]) |-> $past(grant[1] && wbus_idle))
      else $error("slice started without grant and idle");
   AST_SL_END: assert property (slice_expired[1] && !grant[1] |=> slice_expired[1] == 1'b0)
      else $error("slice not cleared on grant drop");
   CV_SLICE: cover property ($rose(slice_expired[1]));
   CV_GATE: cover property (cfg_target_wr_ok);
   CV_READ: cover property (rd && addr == 8'h91);
endmodule
bind ialc_bank ialc_bank_sva #(.ADDR_W(ADDR_W)) i_sva (.mclk, .rst_n, .addr, .wdata, .wr,
   .rd, .rdata, .grant, .wbus_idle, .slice_hold, .slice_expired, .wbus_pipe_en, .ratio_2x,
   .ratio_2p5x, .ratio_3x, .ratio_reserved, .bcast_en, .unlock, .cfg_target_wr_ok);

// ### tb/ialc_bank_tb.sv
// Purpose: Self-checking bench for the arbiter slice and lock bank.
// Assumes: Inputs move by NB at rising edges; checks 1 ns later, read answers at the edge.
// Notes:   Read answers are queued and judged by the monitor.
`timescale 1ns/1ps
module ialc_bank_tb
   import ialc_pkg::*;
;
   logic       mclk, rst_n, wr, rd, wbus_idle, rbus_idle, mem_read_issued, rd_seen = 1'b0;
   logic       wbus_pipe_en, ratio_2x, ratio_2p5x, ratio_3x, ratio_reserved, bcast_en;
   logic       pci33_retry_ok, cfg_target_wr_ok;
   logic [7:0] addr, wdata, rdata, unlock, v, q[$];
   logic [4:0] grant, slice_hold, slice_expired;
   logic [7:0] ofs[7] = '{8'h8d, 8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'haf};
   logic [7:0] msk[7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h13, 8'h00, 8'h00};
   logic [7:0] tgt[8] = '{8'h2c, 8'h34, 8'he8, 8'h02, 8'hed, 8'he0, 8'hb0, 8'h3c};
   logic [7:0] sa[5] = '{8'h8d, 8'h8e, 8'h8e, 8'h8f, 8'h8f};
   int         sh[5] = '{5, 4, 0, 4, 0};
   int         n_mismatch, compares, seed, i, n, k;
   ialc_bank i_dut (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .grant, .wbus_idle,
      .rbus_idle, .mem_read_issued, .slice_hold, .slice_expired, .pci33_retry_ok,
      .wbus_pipe_en, .ratio_2x, .ratio_2p5x, .ratio_3x, .ratio_reserved, .bcast_en, .unlock,
      .cfg_target_wr_ok);
   task chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
            input logic [7:0] e);
      @(posedge mclk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      if (r)
         q.push_back(e);
   endtask
   task wrap_up;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Judged at the edge, before the answer register moves on
   always @(posedge mclk)
   begin
      if (rst_n && rd_seen)
         chk(rdata, q.pop_front());
      rd_seen <= rd && rst_n;
   end
   initial
   begin
      #200000;
      n_mismatch++;
      wrap_up;
   end
   initial
   begin
      seed = 32'h0557ae75;
      {rst_n, wr, rd, wbus_idle, rbus_idle, mem_read_issued, grant, addr, wdata} = '0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1 chk({bcast_en, ratio_reserved, wbus_pipe_en}, 8'h06);
      for (k = 0; k < 7; k++)
         bus(0, 1, ofs[k], 8'h00, (k == 4) ? 8'h13 : 8'h00);
      for (k = 0; k < 7; k++)
      begin
         v = 8'($random(seed));
         bus(1, 0, ofs[k], v, 8'h00);
         bus(0, 1, ofs[k], 8'h00, v & msk[k]);
      end
      for (k = 0; k < 16; k++)
      begin
         bus(1, 0, 8'h8d, 8'(k), 8'h00);
         bus(0, 0, 8'h00, 8'h00, 8'h00);
         #1 chk({ratio_2x, ratio_2p5x, ratio_3x, ratio_reserved},
                (k % 8 == 6) ? 8 : (k % 8 == 5) ? 4 : (k % 8 == 3) ? 2 : 1);
         chk(wbus_pipe_en, 8'(k / 8));
      end
      // Software setting for a 100 MHz host keeps PCI near 33 MHz
      bus(1, 0, 8'h8d, 8'h03, 8'h00);
      bus(0, 1, 8'h8d, 8'h00, 8'h03);
      #1 chk(ratio_3x, 8'h01);
      // Every other lock bit set first, so only the own bit may open
      for (k = 0; k < 8; k++)
      begin
         v = 8'h01 << k;
         bus(1, 0, 8'h90, ~v, 8'h00);
         bus(1, 0, tgt[k], 8'h00, 8'h00);
         #1 chk(cfg_target_wr_ok, 8'h00);
         bus(1, 0, 8'h90, v, 8'h00);
         bus(1, 0, tgt[k], 8'h00, 8'h00);
         #1 chk(cfg_target_wr_ok, 8'h01);
         chk(unlock, v);
      end
      for (i = 0; i < 5; i++)
      begin
         n = (i == 0) ? 7 : (i == 1) ? 15 : (i == 2) ? 0 : ($random(seed) & 15);
         bus(1, 0, sa[i], 8'(n << sh[i]), 8'h00);
         bus(0, 0, 8'h00, 8'h00, 8'h00);
         grant[i] <= 1'b1;
         repeat (3) @(posedge mclk);
         #1 chk({slice_hold[i], slice_expired[i]}, 8'h00);
         @(posedge mclk);
         wbus_idle <= 1'b1;
         rbus_idle <= 1'b1;
         k = 0;
         repeat (20)
         begin
            @(posedge mclk);
            #1 k = k + slice_hold[i];
         end
         chk(8'(k), 8'(n));
         chk(slice_expired[i], 8'h01);
         if (i == 4)
         begin
            #1 chk(pci33_retry_ok, 8'h00);
            @(posedge mclk);
            mem_read_issued <= 1'b1;
            #1 chk(pci33_retry_ok, 8'h01);
            @(posedge mclk);
            mem_read_issued <= 1'b0;
            bus(1, 0, 8'h8d, 8'h10, 8'h00);
            bus(0, 0, 8'h00, 8'h00, 8'h00);
            #1 chk(pci33_retry_ok, 8'h01);
         end
         @(posedge mclk);
         grant[i] <= 1'b0;
         wbus_idle <= 1'b0;
         rbus_idle <= 1'b0;
         repeat (2) @(posedge mclk);
         #1 chk({slice_hold[i], slice_expired[i]}, 8'h00);
      end
      bus(0, 0, 8'h00, 8'h00, 8'h00);
      repeat (3) @(posedge mclk);
      wrap_up;
   end
endmodule
